// ### logic/otfq_format.sv
// Result word coder: 1/32 degree signed value to the left-justified formats.
// Assumes temperatures arrive as signed 16-bit counts of 1/32 degree.
`timescale 1ns/10ps
module otfq_format import otfq_pkg::*; (
  input wire logic [15:0] temp_i,
  input wire logic filt_i,
  input wire logic fault_i,
  output logic [15:0] signed_o,
  output logic [15:0] unsigned_o
);
  logic [12:0] s13;
  logic [12:0] u13;
  logic [15:0] s_pre;
  logic [15:0] u_pre;

  // Clamp a signed 1/32 count into 13 bits, signed or unsigned.
  function automatic logic [12:0] otfq_clamp(input logic [15:0] t, input logic uns);
    logic signed [15:0] v;
    v = signed'(t);
    if (uns) begin
      if (v < 0) otfq_clamp = 13'h0000;
      else if (v > 16'sh1FFF) otfq_clamp = 13'h1FFF;
      else otfq_clamp = t[12:0];
    end else begin
      if (v < -16'sh1000) otfq_clamp = 13'h1000;
      else if (v > 16'sh0FFF) otfq_clamp = 13'h0FFF;
      else otfq_clamp = t[12:0];
    end
  endfunction

  always_comb begin
    s13 = otfq_clamp(temp_i, 1'b0);
    u13 = otfq_clamp(temp_i, 1'b1);
    // Unfiltered words keep 11 bits; lower bits read zero.
    s_pre = filt_i ? {s13, 3'h0} : {s13[12:2], 5'h00};
    u_pre = filt_i ? {u13, 3'h0} : {u13[12:2], 5'h00};
    signed_o = fault_i ? `OTFQ_S_FAULT : s_pre;
    unsigned_o = fault_i ? `OTFQ_U_FAULT : u_pre;
  end
endmodule // otfq_format

// ### logic/otfq_params.svh
// Constants of the over-temperature persistence and result formatting block.
// Assumes inclusion by the package, compiled ahead of every module of the block.
`ifndef OTFQ_PARAMS_SVH
`define OTFQ_PARAMS_SVH
`define OTFQ_PERSIST_COUNT 2'h3
`define OTFQ_CFG_Q3_BIT 0
`define OTFQ_CFG_Q4_BIT 1
`define OTFQ_CFG_RESET 8'h03
`define OTFQ_FRAC_BITS 5
`define OTFQ_S11_MAX 13'h0FFF
`define OTFQ_S11_MIN 13'h1000
`define OTFQ_S_FAULT 16'h8000
`define OTFQ_U_FAULT 16'h0000
`define OTFQ_RES_LOCAL 4'h0
`define OTFQ_RES_NUM 4'h9
`endif

// ### logic/otfq_pkg.sv
// Types shared by the persistence filter and result formatter.
// Assumes the params header sits on the include path.
package otfq_pkg;
  `include "otfq_params.svh"
  // One conversion report from the converter: 1/32 degree signed value.
  typedef struct packed {
    logic done;
    logic [2:0] chan;
    logic filt;
    logic fault;
    logic [15:0] temp;
  } otfq_conv_type;
  // Compare results for one conversion on the queued channels.
  typedef struct packed {
    logic above;
    logic below_hyst;
  } otfq_cmp_type;
  typedef struct packed {
    logic [1:0] up_cnt;
    logic [1:0] dn_cnt;
    logic hot;
  } otfq_queue_type;
endpackage

// ### logic/otfq_queue.sv
// Persistence filter for one queued remote channel.
// Assumes a conversion-end pulse for this channel with its compare results beside it.
`timescale 1ns/10ps
module otfq_queue import otfq_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic conv_done_i,
  input wire otfq_cmp_type cmp_i,
  output logic hot_o
);
  otfq_queue_type st_r;
  otfq_queue_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (conv_done_i) begin
      if (!enable_i) begin
        st_nxt.up_cnt = 2'h0;
        st_nxt.dn_cnt = 2'h0;
        if (cmp_i.above) st_nxt.hot = 1'b1;
        else if (cmp_i.below_hyst) st_nxt.hot = 1'b0;
      end else begin
        st_nxt.up_cnt = cmp_i.above ? st_r.up_cnt + 2'h1 : 2'h0;
        st_nxt.dn_cnt = cmp_i.below_hyst ? st_r.dn_cnt + 2'h1 : 2'h0;
        if (st_nxt.up_cnt == `OTFQ_PERSIST_COUNT) begin
          st_nxt.hot = 1'b1;
          st_nxt.up_cnt = 2'h0;
        end else if (st_nxt.dn_cnt == `OTFQ_PERSIST_COUNT) begin
          // A set and a release in one conversion cannot both be honoured; the set wins.
          st_nxt.hot = 1'b0;
          st_nxt.dn_cnt = 2'h0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign hot_o = st_r.hot;

  property p_no_change_idle;
    @(posedge clk_sys_i) disable iff (rst_i) !conv_done_i |=> $stable(hot_o);
  endproperty
  a_no_change_idle: assert property (p_no_change_idle) else $error("alert moved idle");
  property p_single_release;
    @(posedge clk_sys_i) disable iff (rst_i)
      (enable_i && conv_done_i && cmp_i.below_hyst && st_r.dn_cnt == 2'h0 && hot_o)
      |=> hot_o;
  endproperty
  a_single_release: assert property (p_single_release) else $error("released early");
  property p_unq_set;
    @(posedge clk_sys_i) disable iff (rst_i) (!enable_i && conv_done_i && cmp_i.above) |=> hot_o;
  endproperty
  a_unq_set: assert property (p_unq_set) else $error("unqueued set missed");
  c_set: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(hot_o));
  c_clr: cover property (@(posedge clk_sys_i) disable iff (rst_i) $fell(hot_o));
endmodule // otfq_queue

// ### logic/otfq_top.sv
// Persistence-gated alerts and byte readback of temperature results.
// Assumes a converter reporting one channel per done pulse, and mask/limit compares outside.
`timescale 1ns/10ps
module otfq_top import otfq_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire otfq_conv_type conv_i,
  input wire otfq_cmp_type cmp_r3_i,
  input wire otfq_cmp_type cmp_r4_i,
  input wire logic [2:0] other_hot_a_i,
  input wire logic [2:0] other_hot_b_i,
  input wire logic [2:0] other_hot_c_i,
  input wire logic [5:0] mask_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic serial_low_i,
  output logic [7:0] reg_rdata_o,
  output logic overtemp_alert_a_o,
  output logic overtemp_alert_a_oe_n_o,
  output logic overtemp_alert_b_o,
  output logic overtemp_alert_b_oe_n_o,
  output logic overtemp_alert_c_o,
  output logic overtemp_alert_c_oe_n_o,
  output logic serial_data_o,
  output logic serial_data_oe_n_o
);
  // Result address map: 0 local signed, 1..4 remote signed, 5..8 remote unsigned.
  // High byte at 2*index+0x10, low byte one above; configuration at 0x03.
  localparam logic [7:0] CFG_ADDR = 8'h03;
  localparam logic [7:0] RES_BASE = 8'h10;

  typedef struct packed {
    logic [7:0] cfg;
    logic [8:0][15:0] res;
    logic [8:0][7:0] lo_hold;
    logic [8:0] lo_lock;
    logic [7:0] rdata;
  } otfq_top_type;

  otfq_top_type st_r;
  otfq_top_type st_nxt;
  logic [15:0] fmt_s;
  logic [15:0] fmt_u;
  logic hot3;
  logic hot4;
  logic done3;
  logic done4;
  logic [7:0] roff;
  logic [3:0] ridx;
  logic rhi;
  logic rsel;

  assign done3 = conv_i.done && conv_i.chan == 3'h3;
  assign done4 = conv_i.done && conv_i.chan == 3'h4;

  otfq_format u_format (
    .temp_i(conv_i.temp),
    .filt_i(conv_i.filt && (conv_i.chan == 3'h1 || conv_i.chan == 3'h2)),
    .fault_i(conv_i.fault && conv_i.chan != 3'h0),
    .signed_o(fmt_s),
    .unsigned_o(fmt_u)
  );

  otfq_queue u_q3 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .enable_i(st_r.cfg[`OTFQ_CFG_Q3_BIT]),
    .conv_done_i(done3),
    .cmp_i(cmp_r3_i),
    .hot_o(hot3)
  );

  otfq_queue u_q4 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .enable_i(st_r.cfg[`OTFQ_CFG_Q4_BIT]),
    .conv_done_i(done4),
    .cmp_i(cmp_r4_i),
    .hot_o(hot4)
  );

  always_comb begin
    // Offset from the result base, so index 8 at 20h and 21h decodes like the rest.
    roff = reg_addr_i - RES_BASE;
    ridx = roff[4:1];
    rhi = !roff[0];
    rsel = reg_addr_i >= RES_BASE && roff[7:1] < 7'(`OTFQ_RES_NUM);
  end

  always_comb begin
    st_nxt = st_r;
    // Channel codes above four are ignored so they cannot overwrite the unsigned words.
    if (conv_i.done && conv_i.chan <= 3'h4) begin
      st_nxt.res[conv_i.chan] = fmt_s;
      if (conv_i.chan != 3'h0) st_nxt.res[4'(conv_i.chan) + 4'h4] = fmt_u;
    end
    if (reg_wr_i && reg_addr_i == CFG_ADDR) st_nxt.cfg = reg_wdata_i;
    st_nxt.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == CFG_ADDR) st_nxt.rdata = st_r.cfg;
      else if (rsel && rhi) begin
        st_nxt.rdata = st_r.res[ridx][15:8];
        st_nxt.lo_hold[ridx] = st_r.res[ridx][7:0];
        st_nxt.lo_lock[ridx] = 1'b1;
      end else if (rsel) begin
        st_nxt.rdata = st_r.lo_lock[ridx] ? st_r.lo_hold[ridx] : st_r.res[ridx][7:0];
        st_nxt.lo_lock[ridx] = 1'b0;
      end
      // Any other address reads zero, so no temperature leaks elsewhere.
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.cfg <= `OTFQ_CFG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;

  // Alerts are open drain: only ever drive a zero.
  logic act_a;
  logic act_b;
  logic act_c;
  always_comb begin
    act_a = |other_hot_a_i || (hot3 && !mask_i[0]) || (hot4 && !mask_i[1]);
    act_b = |other_hot_b_i || (hot3 && !mask_i[2]) || (hot4 && !mask_i[3]);
    act_c = |other_hot_c_i || (hot3 && !mask_i[4]) || (hot4 && !mask_i[5]);
  end
  assign overtemp_alert_a_o = 1'b0;
  assign overtemp_alert_b_o = 1'b0;
  assign overtemp_alert_c_o = 1'b0;
  assign overtemp_alert_a_oe_n_o = !act_a;
  assign overtemp_alert_b_oe_n_o = !act_b;
  assign overtemp_alert_c_oe_n_o = !act_c;
  assign serial_data_o = 1'b0;
  assign serial_data_oe_n_o = !serial_low_i;

  property p_mask_blocks;
    @(posedge clk_sys_i) disable iff (rst_i)
      (other_hot_a_i == 3'h0 && mask_i[1:0] == 2'h3) |-> overtemp_alert_a_oe_n_o;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked alert active");
  property p_alert_hot;
    @(posedge clk_sys_i) disable iff (rst_i) (hot3 && !mask_i[2]) |-> !overtemp_alert_b_oe_n_o;
  endproperty
  a_alert_hot: assert property (p_alert_hot) else $error("alert not driven");
  property p_never_high;
    @(posedge clk_sys_i) disable iff (rst_i)
      !overtemp_alert_c_o && !serial_data_o;
  endproperty
  a_never_high: assert property (p_never_high) else $error("drove high");
  property p_cfg_reset;
    @(posedge clk_sys_i) $fell(rst_i) |-> st_r.cfg[1:0] == 2'h3;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("queue off at reset");
  property p_lo_frozen;
    @(posedge clk_sys_i) disable iff (rst_i)
      (reg_rd_i && rsel && rhi) |=> st_r.lo_lock[$past(ridx)];
  endproperty
  a_lo_frozen: assert property (p_lo_frozen) else $error("low byte not locked");
  property p_unused_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
      (reg_rd_i && !rsel && reg_addr_i != CFG_ADDR) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("stray read data");
  property p_fault_code;
    @(posedge clk_sys_i) disable iff (rst_i)
      (conv_i.done && conv_i.fault && conv_i.chan == 3'h3) |=> st_r.res[3] == `OTFQ_S_FAULT
        && st_r.res[7] == `OTFQ_U_FAULT;
  endproperty
  a_fault_code: assert property (p_fault_code) else $error("fault code wrong");
  property p_low_bits;
    @(posedge clk_sys_i) disable iff (rst_i) st_r.res[0][4:0] == 5'h00;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("local low bits set");
  c_hi_then_lo: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && rsel && rhi) ##1 (reg_rd_i && rsel && !rhi));
  c_cfg_wr: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == CFG_ADDR);
  c_alert: cover property (@(posedge clk_sys_i) disable iff (rst_i) !overtemp_alert_a_oe_n_o);
endmodule // otfq_top

// ### sim/otfq_host_model.sv
// Host side of the open-drain alert and serial data lines.
// Assumes active-low output enables from the sensor block.
`timescale 1ns/10ps
module otfq_host_model (
  input wire logic [2:0] oe_n_i,
  input wire logic [2:0] drv_i,
  input wire logic sda_oe_n_i,
  input wire logic sda_i,
  output logic [2:0] line_o,
  output logic sda_line_o
);
  // A released line goes to the pull-up, so a stale driven value cannot hide.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      line_o[i] = oe_n_i[i] ? 1'b1 : drv_i[i];
    end
    sda_line_o = sda_oe_n_i ? 1'b1 : sda_i;
  end
endmodule // otfq_host_model

// ### sim/otfq_top_tb.sv
// Self-checking bench for the persistence filter and result readback.
// Assumes the design files and the host model are compiled before it.
`timescale 1ns/10ps
module otfq_top_tb import otfq_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  otfq_conv_type conv = '0;
  otfq_cmp_type c3 = '0;
  otfq_cmp_type c4 = '0;
  logic [2:0] oh_a = '0, oh_b = '0, oh_c = '0;
  logic [5:0] mask = '0;
  logic [7:0] addr = '0, wdata = '0, rdata;
  logic wr = 1'b0, rd = 1'b0, sl = 1'b0;
  logic [2:0] al_d, al_oe, line;
  logic sd, sd_oe, sd_line;
  int fail_count = 0;
  int tests_run = 0;
  logic [15:0] ct[9] = '{16'h0FA0, 16'h0020, 16'hFFFC, 16'h1920, 16'h1FFF, 16'h0001,
    16'hFFFF, 16'h2328, 16'hDCD8};
  logic [15:0] cs[9] = '{16'h7D00, 16'h0100, 16'hFFE0, 16'h7FE0, 16'h7FE0, 16'h0008,
    16'hFFF8, 16'h7FF8, 16'h8000};
  logic [15:0] cu[9] = '{16'h7D00, 16'h0100, 16'h0000, 16'hC900, 16'hFFE0, 16'h0008,
    16'h0000, 16'hFFF8, 16'h0000};
  logic [8:0] cflt = 9'h1E0;
  // Codes: 2 above, 1 below, 0 neither, 3 a local conversion that must not count.
  logic [1:0] qc[13] = '{2'h2, 2'h0, 2'h2, 2'h2, 2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h1,
    2'h3, 2'h1, 2'h1};
  logic [12:0] qh = 13'h0FE0;
  always #12.5 clk = ~clk;
  otfq_top uut (.clk_sys_i(clk), .rst_i(rst), .conv_i(conv), .cmp_r3_i(c3), .cmp_r4_i(c4),
    .other_hot_a_i(oh_a), .other_hot_b_i(oh_b), .other_hot_c_i(oh_c), .mask_i(mask),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .serial_low_i(sl), .reg_rdata_o(rdata), .overtemp_alert_a_o(al_d[0]),
    .overtemp_alert_a_oe_n_o(al_oe[0]), .overtemp_alert_b_o(al_d[1]),
    .overtemp_alert_b_oe_n_o(al_oe[1]), .overtemp_alert_c_o(al_d[2]),
    .overtemp_alert_c_oe_n_o(al_oe[2]), .serial_data_o(sd), .serial_data_oe_n_o(sd_oe));
  otfq_host_model u_host (.oe_n_i(al_oe), .drv_i(al_d), .sda_oe_n_i(sd_oe), .sda_i(sd),
    .line_o(line), .sda_line_o(sd_line));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cv(logic [2:0] ch, logic flt, logic f, logic [15:0] t, logic [1:0] c);
    @(posedge clk);
    conv <= {1'b1, ch, flt, f, t};
    c3 <= c;
    c4 <= c;
    @(posedge clk);
    conv.done <= 1'b0;
    #1;
  endtask
  task automatic res(int k, logic [15:0] e);
    logic [7:0] h;
    logic [7:0] l;
    rd_reg(8'h10 + 8'(2 * k), h);
    rd_reg(8'h11 + 8'(2 * k), l);
    check("result", {h, l}, e);
  endtask
  task automatic qchk(logic hot);
    logic [2:0] e;
    e = {~hot, ~hot, 1'b1};
    check("alerts", {7'h00, al_d, line, al_oe}, {7'h00, 3'h0, e, e});
  endtask
  // Saturate in 1/32 degree steps first, then drop the bits the format does not carry.
  function automatic logic [15:0] exp_w(logic [15:0] t, logic u, logic f, logic flt);
    logic signed [16:0] v;
    logic signed [16:0] lo;
    logic signed [16:0] hi;
    v = signed'({t[15], t});
    lo = u ? 17'sh00000 : 17'sh1F000;
    hi = u ? 17'sh01FFF : 17'sh00FFF;
    v = v < lo ? lo : (v > hi ? hi : v);
    if (f) begin
      return u ? 16'h0000 : 16'h8000;
    end
    return {v[12:0], 3'h0} & (flt ? 16'hFFF8 : 16'hFFE0);
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
  initial begin
    logic [7:0] h;
    logic [7:0] l;
    logic [15:0] t;
    logic [2:0] ch;
    logic f;
    logic flt;
    logic [2:0] e3;
    void'($urandom(21));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h03, h);
    check("cfg reset", {8'h00, h}, 16'h0003);
    wr_reg(8'h30, 8'hFF);
    rd_reg(8'h03, h);
    check("cfg kept", {8'h00, h}, 16'h0003);
    for (int i = 0; i < 9; i++) begin
      cv(3'h1, cflt[i], 1'b0, ct[i], 2'h0);
      res(1, cs[i]);
      res(5, cu[i]);
    end
    cv(3'h2, 1'b0, 1'b1, 16'h0100, 2'h0);
    res(2, 16'h8000);
    res(6, 16'h0000);
    for (int n = 0; n < 40; n++) begin
      ch = 3'($urandom_range(4, 0));
      t = 16'($urandom_range(15000, 0) - 6000);
      flt = 1'($urandom);
      f = 1'($urandom_range(3, 0) == 0);
      cv(ch, flt, f, t, 2'h0);
      flt = flt && (ch == 3'h1 || ch == 3'h2);
      res(ch, exp_w(t, 1'b0, f && ch != 3'h0, flt));
      if (ch != 3'h0) begin
        res(ch + 4, exp_w(t, 1'b1, f, flt));
      end
    end
    cv(3'h1, 1'b0, 1'b0, 16'h0011, 2'h0);
    rd_reg(8'h12, h);
    cv(3'h1, 1'b0, 1'b0, 16'h0027, 2'h0);
    rd_reg(8'h12, h);
    cv(3'h1, 1'b0, 1'b0, 16'h004C, 2'h0);
    rd_reg(8'h13, l);
    check("locked", {h, l}, exp_w(16'h0027, 1'b0, 1'b0, 1'b0));
    for (int a = 8'h22; a < 8'h30; a++) begin
      rd_reg(8'(a), h);
      check("unmapped", {8'h00, h}, 16'h0000);
    end
    for (int b = 0; b < 2; b++) begin
      mask <= 6'h01 << b;
      for (int i = 0; i < 13; i++) begin
        cv(qc[i] == 2'h3 ? 3'h0 : 3'(3 + b), 1'b0, 1'b0, 16'h0000, qc[i] == 2'h3 ? 2'h2 : qc[i]);
        qchk(qh[i]);
      end
      wr_reg(8'h03, 8'h02 >> b);
      cv(3'(3 + b), 1'b0, 1'b0, 16'h0000, 2'h2);
      qchk(1'b1);
      cv(3'(3 + b), 1'b0, 1'b0, 16'h0000, 2'h1);
      qchk(1'b0);
      wr_reg(8'h03, 8'h03);
    end
    // Remote three is left hot so the masks decide the alerts during the random mix.
    for (int i = 0; i < 3; i++) begin
      cv(3'h3, 1'b0, 1'b0, 16'h0000, 2'h2);
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      sl <= 1'($urandom);
      oh_a <= i == 0 ? 3'h0 : 3'($urandom);
      oh_b <= 3'($urandom);
      oh_c <= 3'($urandom);
      mask <= i == 0 ? 6'h03 : 6'($urandom);
      #1 check("serial", {13'h0000, sd, sd_line, sd_oe}, {13'h0000, 1'b0, ~sl, ~sl});
      e3 = ~{|oh_c | ~mask[4], |oh_b | ~mask[2], |oh_a | ~mask[0]};
      check("other", {13'h0000, al_oe}, {13'h0000, e3});
    end
    wr_reg(8'h03, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h03, h);
    check("cfg re-reset", {8'h00, h}, 16'h0003);
    end_of_test;
  end
endmodule // otfq_top_tb
